/* File: hw/slave_port_pkg.sv */
// shared constants and types for the slave processor host port
// ============================================================
// system bus map of one board
package slave_port_pkg;
	localparam logic [15:0] SELECT_PORT = 16'hfc40;
	localparam logic [15:0] CONTROL_PORT = 16'hfc41;
	localparam logic [15:0] LOW_IO_FIRST = 16'hfc30;
	localparam logic [15:0] LOW_IO_LAST = 16'hfc3f;
	localparam logic [15:0] HIGH_IO_FIRST = 16'hfc42;
	localparam logic [15:0] HIGH_IO_LAST = 16'hfc47;
	localparam logic [19:0] WINDOW_BASE = 20'he0000;
	localparam int BOARD_COUNT = 16;
	// ============================================================
	// control latch contents
	localparam int RUN_BIT = 3;
	localparam logic [7:0] RUN_VALUE = 8'h08;
	localparam logic [7:0] STOP_VALUE = 8'h00;
	localparam logic [7:0] SELECT_RESET = 8'hff;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [7:0] HALT_OPCODE = 8'h76;
	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int RESET_HOLD_NS = 1000;
	localparam int RESET_HOLD_CYCLES =
		(RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PARK_TRIES = 4;
	// ============================================================
	// host controller register map
	localparam logic [3:0] HR_ADDR_LO = 4'h0;
	localparam logic [3:0] HR_ADDR_MID = 4'h1;
	localparam logic [3:0] HR_ADDR_HI = 4'h2;
	localparam logic [3:0] HR_WDATA = 4'h3;
	localparam logic [3:0] HR_BOARD = 4'h4;
	localparam logic [3:0] HR_CMD = 4'h5;
	localparam logic [3:0] HR_STATUS = 4'h6;
	localparam logic [3:0] HR_RDATA = 4'h7;
	localparam int CMD_WE_BIT = 0;
	localparam int CMD_IO_BIT = 1;
	localparam int CMD_MODE_LSB = 4;
	localparam int ST_BUSY = 0;
	localparam int ST_STALL = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_PARK_FAIL = 3;
	localparam int ST_RUN = 4;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_PARK = 2'b01,
		MODE_RESTART = 2'b10
	} mode_e;

	typedef struct packed {
		logic io;
		logic we;
		logic [19:0] addr;
		logic [7:0] data;
	} op_s;
endpackage: slave_port_pkg

/* File: hw/slave_bus_if.sv */
// system bus segment between host controller and one slave board
`timescale 1ns/1ns
interface slave_bus_if;
	logic stb;
	logic io;
	logic we;
	logic [19:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic stall;
	logic [7:0] rdata;
	modport host (
		output stb, io, we, addr, wdata,
		input ack, stall, rdata
	);
	modport board (
		input stb, io, we, addr, wdata,
		output ack, stall, rdata
	);
endinterface: slave_bus_if

/* File: hw/board_port.sv */
// board end of the slave processor host port
`timescale 1ns/1ns
// ============================================================
// Summary of operation
// - board number written to select port picks board
// - latch value with bit 3 releases processor
// - latch zero resets processor of selected board
// - released processor starts at local address zero
// - power-up: reset held, no refresh, no grant
// - gated access in reset stalls until grant
// - host releases reset before gated accesses
// - window base maps to local address zero
// - halted processor refreshes; window stays usable
// - lower port block reachable while halted
// - host parks processor with verified halt opcode
// - host holds reset long enough before release in park and restart only
// - host starts program via jump and reset
module board_port
	import slave_port_pkg::*;
#(
	parameter logic [3:0] BOARD_NUM = 4'h0
) (
	input wire logic clk,
	input wire logic reset_n,
	slave_bus_if.board bus,
	output logic cpu_reset_n,
	output logic cpu_start,
	output logic [15:0] cpu_start_addr,
	output logic refresh_en,
	output logic bus_request,
	input wire logic local_bus_grant_ack,
	output logic [15:0] loc_addr,
	output logic loc_io,
	output logic [7:0] loc_wdata,
	output logic loc_we,
	output logic loc_re,
	input wire logic [7:0] loc_rdata
);

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_REQ = 3'b001,
		D_XFER = 3'b010,
		D_RDATA = 3'b011,
		D_ACK = 3'b100
	} dev_state_e;

	dev_state_e state_ff;
	dev_state_e nxt_state;
	logic grant_s1_ff;
	logic grant_s2_ff;
	logic [7:0] select_ff;
	logic [7:0] control_ff;
	logic start_ff;
	logic [15:0] start_addr_ff;
	logic request_ff;
	logic [15:0] addr_ff;
	logic io_ff;
	logic we_ff;
	logic [7:0] wdata_ff;
	logic [7:0] rdata_ff;
	logic [15:0] port;
	logic hit_select;
	logic hit_control;
	logic hit_low;
	logic hit_high;
	logic hit_mem;
	logic selected;
	logic take_reg;
	logic take_loc;
	logic run;

	// ============================================================
	// grant synchroniser
	// grant comes from the local processor, not from this clock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			grant_s1_ff <= 1'b0;
			grant_s2_ff <= 1'b0;
		end else begin
			grant_s1_ff <= local_bus_grant_ack;
			grant_s2_ff <= grant_s1_ff;
		end
	end

	// ============================================================
	// address decode
	assign port = bus.addr[15:0];
	assign hit_select = bus.io && (port == SELECT_PORT);
	assign hit_control = bus.io && (port == CONTROL_PORT);
	assign hit_low = bus.io && (port >= LOW_IO_FIRST) &&
		(port <= LOW_IO_LAST);
	assign hit_high = bus.io && (port >= HIGH_IO_FIRST) &&
		(port <= HIGH_IO_LAST);
	assign hit_mem = !bus.io &&
		(bus.addr[19:16] == WINDOW_BASE[19:16]);
	assign selected = (select_ff < 8'(BOARD_COUNT)) &&
		(select_ff[3:0] == BOARD_NUM);
	assign take_reg = (state_ff == D_IDLE) && bus.stb &&
		(hit_select || hit_control);
	// a board answers for the window and port blocks only while selected
	assign take_loc = (state_ff == D_IDLE) && bus.stb && selected &&
		(hit_mem || hit_low || hit_high);

	// ============================================================
	// board select latch
	// every board listens, so the choice is seen system wide
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			select_ff <= SELECT_RESET;
		end else if (take_reg && bus.we && hit_select) begin
			select_ff <= bus.wdata;
		end
	end

	// ============================================================
	// processor control latch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			control_ff <= CONTROL_RESET;
		end else if (take_reg && bus.we && hit_control && selected) begin
			control_ff <= bus.wdata;
		end
	end

	assign run = control_ff[RUN_BIT];
	assign cpu_reset_n = run;
	// a halted processor still runs its refresh cycles
	assign refresh_en = run;

	// ============================================================
	// start pulse and fetch address
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_ff <= 1'b0;
			start_addr_ff <= RESET_VECTOR;
		end else begin
			start_ff <= take_reg && bus.we && hit_control && selected &&
				!run && bus.wdata[RUN_BIT];
			start_addr_ff <= RESET_VECTOR;
		end
	end

	assign cpu_start = start_ff;
	assign cpu_start_addr = start_addr_ff;

	// ============================================================
	// local bus request
	// no grant can come while the latch holds the processor in reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			request_ff <= 1'b0;
		end else if (take_loc) begin
			request_ff <= 1'b1;
		end else if (state_ff == D_ACK) begin
			request_ff <= 1'b0;
		end
	end

	assign bus_request = request_ff;

	// ============================================================
	// captured host access
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_ff <= 16'h0000;
			io_ff <= 1'b0;
			we_ff <= 1'b0;
			wdata_ff <= 8'h00;
		end else if (take_loc) begin
			// window offset is the local address
			addr_ff <= bus.addr[15:0];
			io_ff <= bus.io;
			we_ff <= bus.we;
			wdata_ff <= bus.wdata;
		end
	end

	assign loc_addr = addr_ff;
	assign loc_io = io_ff;
	assign loc_wdata = wdata_ff;
	assign loc_we = (state_ff == D_XFER) && we_ff;
	assign loc_re = (state_ff == D_XFER) && !we_ff;

	// ============================================================
	// read data
	// both latches are write only and read back as zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 8'h00;
		end else if (take_reg) begin
			rdata_ff <= 8'h00;
		end else if (state_ff == D_RDATA) begin
			rdata_ff <= loc_rdata;
		end
	end

	assign bus.rdata = rdata_ff;

	// ============================================================
	// access sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			D_IDLE: begin
				if (take_reg) begin
					nxt_state = D_ACK;
				end else if (take_loc) begin
					nxt_state = D_REQ;
				end
			end
			D_REQ: begin
				if (grant_s2_ff) begin
					nxt_state = D_XFER;
				end
			end
			D_XFER: begin
				nxt_state = we_ff ? D_ACK : D_RDATA;
			end
			D_RDATA: begin
				nxt_state = D_ACK;
			end
			D_ACK: begin
				nxt_state = D_IDLE;
			end
			default: begin
				nxt_state = D_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= D_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// wait state lasts from the request to the answer
	assign bus.stall = (state_ff == D_REQ) || (state_ff == D_XFER) ||
		(state_ff == D_RDATA);
	assign bus.ack = (state_ff == D_ACK);

endmodule: board_port

/* File: hw/host_port.sv */
// host end: command controller driving the slave board port
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
module host_port
	import slave_port_pkg::*;
#(
	parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
	parameter int TRIES = PARK_TRIES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	slave_bus_if.host bus
);

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_ISSUE = 3'b001,
		H_WAIT = 3'b010,
		H_HOLD = 3'b011
	} host_state_e;

	host_state_e state_ff;
	mode_e mode_ff;
	logic [19:0] addr_ff;
	logic [7:0] wdata_ff;
	logic [3:0] board_ff;
	logic io_ff;
	logic we_ff;
	logic [2:0] step_ff;
	logic [2:0] tries_ff;
	logic [7:0] hold_ff;
	logic refused_ff;
	logic fail_ff;
	logic run_ff;
	logic [7:0] rdata_ff;
	logic [7:0] reg_rdata_ff;
	logic stb_ff;
	op_s bus_op_ff;
	op_s cur_op;
	logic [2:0] nxt_step;
	logic last_step;
	logic is_stop;
	logic gated;
	logic cmd_go;

	assign cmd_go = reg_wr && (reg_addr == HR_CMD) && (state_ff == H_IDLE);

	// ============================================================
	// command registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_ff <= 20'h00000;
			wdata_ff <= 8'h00;
			board_ff <= 4'h0;
			io_ff <= 1'b0;
			we_ff <= 1'b0;
			mode_ff <= MODE_SINGLE;
		end else if (reg_wr) begin
			case (reg_addr)
				HR_ADDR_LO: addr_ff[7:0] <= reg_wdata;
				HR_ADDR_MID: addr_ff[15:8] <= reg_wdata;
				HR_ADDR_HI: addr_ff[19:16] <= reg_wdata[3:0];
				HR_WDATA: wdata_ff <= reg_wdata;
				HR_BOARD: board_ff <= reg_wdata[3:0];
				HR_CMD: begin
					if (state_ff == H_IDLE) begin
						we_ff <= reg_wdata[CMD_WE_BIT];
						io_ff <= reg_wdata[CMD_IO_BIT];
						// undefined mode 3 would loop; run it as a single
						mode_ff <= (reg_wdata[CMD_MODE_LSB +: 2] == 2'b11) ?
							MODE_SINGLE :
							mode_e'(reg_wdata[CMD_MODE_LSB +: 2]);
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ============================================================
	// step table of park and restart sequences
	always_comb begin
		cur_op = '{io_ff, we_ff, addr_ff, wdata_ff};
		if (mode_ff != MODE_SINGLE) begin
			case (step_ff)
				3'd0: cur_op = '{1'b1, 1'b1, {4'h0, SELECT_PORT},
					{4'h0, board_ff}};
				3'd1: cur_op = '{1'b1, 1'b1, {4'h0, CONTROL_PORT},
					RUN_VALUE};
				3'd2: cur_op = '{1'b0, 1'b1, WINDOW_BASE,
					HALT_OPCODE};
				3'd3: cur_op = '{1'b1, 1'b1, {4'h0, CONTROL_PORT},
					STOP_VALUE};
				3'd4: cur_op = '{1'b1, 1'b1, {4'h0, CONTROL_PORT},
					RUN_VALUE};
				default: cur_op = '{1'b0, 1'b0, WINDOW_BASE, 8'h00};
			endcase
		end
	end

	// restart skips the halt placement; the jump is loaded beforehand
	assign nxt_step = (mode_ff == MODE_RESTART && step_ff == 3'd0) ?
		3'd3 : step_ff + 3'd1;
	assign last_step = (mode_ff == MODE_SINGLE) ||
		(mode_ff == MODE_PARK && step_ff == 3'd5) ||
		(mode_ff == MODE_RESTART && step_ff == 3'd4);
	assign is_stop = cur_op.io && cur_op.we &&
		(cur_op.addr[15:0] == CONTROL_PORT) && !cur_op.data[RUN_BIT];
	// window and board ports would hang the bus while in reset
	assign gated = (mode_ff == MODE_SINGLE) && !run_ff && (!cur_op.io ||
		(cur_op.addr[15:0] >= LOW_IO_FIRST &&
		cur_op.addr[15:0] <= HIGH_IO_LAST &&
		cur_op.addr[15:0] != SELECT_PORT &&
		cur_op.addr[15:0] != CONTROL_PORT));

	// ============================================================
	// sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= H_IDLE;
			step_ff <= 3'd0;
			tries_ff <= 3'd0;
			hold_ff <= 8'h00;
			refused_ff <= 1'b0;
			fail_ff <= 1'b0;
			run_ff <= 1'b0;
			rdata_ff <= 8'h00;
			stb_ff <= 1'b0;
			bus_op_ff <= '0;
		end else begin
			stb_ff <= 1'b0;
			case (state_ff)
				H_IDLE: begin
					if (cmd_go) begin
						step_ff <= 3'd0;
						tries_ff <= 3'd0;
						refused_ff <= 1'b0;
						fail_ff <= 1'b0;
						state_ff <= H_ISSUE;
					end
				end
				H_ISSUE: begin
					if (gated) begin
						refused_ff <= 1'b1;
						state_ff <= H_IDLE;
					end else begin
						stb_ff <= 1'b1;
						bus_op_ff <= cur_op;
						state_ff <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (bus.ack) begin
						if (!cur_op.we) begin
							rdata_ff <= bus.rdata;
						end
						if (cur_op.io && cur_op.we &&
							cur_op.addr[15:0] == CONTROL_PORT) begin
							run_ff <= cur_op.data[RUN_BIT];
						end else if (cur_op.io && cur_op.we &&
							cur_op.addr[15:0] == SELECT_PORT) begin
							run_ff <= 1'b0;
						end
						if (last_step && mode_ff == MODE_PARK &&
							bus.rdata != HALT_OPCODE) begin
							// opcode was overwritten, start over
							if (tries_ff == 3'(TRIES - 1)) begin
								fail_ff <= 1'b1;
								state_ff <= H_IDLE;
							end else begin
								tries_ff <= tries_ff + 3'd1;
								step_ff <= 3'd0;
								state_ff <= H_ISSUE;
							end
						end else if (last_step) begin
							state_ff <= H_IDLE;
						end else if (is_stop) begin
							hold_ff <= 8'(HOLD_CYCLES - 1);
							state_ff <= H_HOLD;
						end else begin
							step_ff <= nxt_step;
							state_ff <= H_ISSUE;
						end
					end
				end
				H_HOLD: begin
					if (hold_ff == 8'h00) begin
						step_ff <= nxt_step;
						state_ff <= H_ISSUE;
					end else begin
						hold_ff <= hold_ff - 8'h01;
					end
				end
				default: begin
					state_ff <= H_IDLE;
				end
			endcase
		end
	end

	assign bus.stb = stb_ff;
	assign bus.io = bus_op_ff.io;
	assign bus.we = bus_op_ff.we;
	assign bus.addr = bus_op_ff.addr;
	assign bus.wdata = bus_op_ff.data;

	// ============================================================
	// register read port
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				HR_ADDR_LO: reg_rdata_ff <= addr_ff[7:0];
				HR_ADDR_MID: reg_rdata_ff <= addr_ff[15:8];
				HR_ADDR_HI: reg_rdata_ff <= {4'h0, addr_ff[19:16]};
				HR_WDATA: reg_rdata_ff <= wdata_ff;
				HR_BOARD: reg_rdata_ff <= {4'h0, board_ff};
				HR_STATUS: begin
					reg_rdata_ff <= 8'h00;
					reg_rdata_ff[ST_BUSY] <= (state_ff != H_IDLE);
					reg_rdata_ff[ST_STALL] <= bus.stall;
					reg_rdata_ff[ST_REFUSED] <= refused_ff;
					reg_rdata_ff[ST_PARK_FAIL] <= fail_ff;
					reg_rdata_ff[ST_RUN] <= run_ff;
				end
				HR_RDATA: reg_rdata_ff <= rdata_ff;
				default: reg_rdata_ff <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_ff;

endmodule: host_port

/* File: tb/slave_port_monitor.sv */
// assertion checker for the bus between host controller and board
`timescale 1ns/1ns
module slave_port_monitor
	import slave_port_pkg::*;
#(
	parameter logic [3:0] BOARD_NUM = 4'h0,
	parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic stb,
	input wire logic io,
	input wire logic we,
	input wire logic [19:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic stall,
	input wire logic cpu_reset_n,
	input wire logic cpu_start,
	input wire logic [15:0] cpu_start_addr,
	input wire logic refresh_en,
	input wire logic bus_request,
	input wire logic local_bus_grant_ack,
	input wire logic [15:0] loc_addr,
	input wire logic [7:0] loc_wdata,
	input wire logic loc_we
);
	// ============================================================
	// helper state
	logic [7:0] sel_ff;
	logic run_sh_ff;
	int low_ff;
	// own copy of the latch run bit, so refresh is not checked against itself
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_sh_ff <= 1'b0;
		end else if (stb && io && we && addr[15:0] == CONTROL_PORT &&
			sel_ff == {4'h0, BOARD_NUM}) begin
			run_sh_ff <= wdata[RUN_BIT];
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_ff <= SELECT_RESET;
		end else if (stb && io && we && addr[15:0] == SELECT_PORT) begin
			sel_ff <= wdata;
		end
	end
	// saturates: power-up reset counts as long enough
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_ff <= 1000;
		end else if (cpu_reset_n) begin
			low_ff <= 0;
		end else if (low_ff < 1000) begin
			low_ff <= low_ff + 1;
		end
	end
	// ============================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence ctl_wr;
		stb && io && we && addr[15:0] == CONTROL_PORT
			&& sel_ff == {4'h0, BOARD_NUM};
	endsequence
	sequence starved;
		(stall && !local_bus_grant_ack) [*2];
	endsequence
	AST_SELECT_ACK: assert property (
		stb && io && we && addr[15:0] == SELECT_PORT |=> ack)
		else $error("select write not answered");
	AST_RUN: assert property (
		ctl_wr ##0 wdata == RUN_VALUE |=> cpu_reset_n && ack)
		else $error("run write left processor in reset");
	AST_STOP: assert property (
		ctl_wr ##0 wdata == STOP_VALUE |=> !cpu_reset_n && ack)
		else $error("stop write left processor running");
	AST_VECTOR: assert property (
		$rose(cpu_reset_n) |-> cpu_start && cpu_start_addr == RESET_VECTOR)
		else $error("release without start at zero");
	AST_NO_REFRESH: assert property (
		!run_sh_ff [*2] |-> !refresh_en && !cpu_reset_n)
		else $error("refresh while processor in reset");
	AST_REFRESH: assert property (
		run_sh_ff [*2] |-> refresh_en && cpu_reset_n)
		else $error("no refresh while processor runs");
	AST_WAIT: assert property (
		starved |=> stall && !ack)
		else $error("wait state ended without grant");
	AST_GRANT_DONE: assert property (
		stall && local_bus_grant_ack |-> ##[1:8] ack)
		else $error("granted access not completed");
	AST_LOCAL_WRITE: assert property (
		loc_we |-> bus_request && loc_addr == addr[15:0]
			&& loc_wdata == wdata)
		else $error("local write address or data wrong");
	AST_HOLD: assert property (
		$rose(cpu_reset_n) |-> low_ff >= HOLD_CYCLES)
		else $error("reset released too early");
endmodule: slave_port_monitor

/* File: tb/slave_processor_host_port_bench.sv */
// self-checking bench: host controller and board joined by the bus
`timescale 1ns/1ns
module slave_processor_host_port_bench;
	import slave_port_pkg::*;
	// short hold keeps the run brief
	localparam int HOLD = 3;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic cpu_reset_n, cpu_start, refresh_en, bus_request, loc_io;
	logic loc_we, loc_re;
	logic [15:0] cpu_start_addr, loc_addr;
	logic [7:0] loc_wdata;
	logic [7:0] loc_rdata = 8'h00;
	logic grant = 1'b0;
	logic grant_en = 1'b1;
	logic [7:0] mem [0:65535];
	logic [7:0] s;
	int starts = 0;
	int error_cnt = 0;
	int cmp_count = 0;
	slave_bus_if bus ();
	host_port #(.HOLD_CYCLES(HOLD), .TRIES(PARK_TRIES)) u_host_port (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bus(bus.host));
	board_port #(.BOARD_NUM(4'h0)) u_board_port (
		.clk(clk), .reset_n(reset_n), .bus(bus.board),
		.cpu_reset_n(cpu_reset_n), .cpu_start(cpu_start),
		.cpu_start_addr(cpu_start_addr), .refresh_en(refresh_en),
		.bus_request(bus_request), .local_bus_grant_ack(grant),
		.loc_addr(loc_addr), .loc_io(loc_io), .loc_wdata(loc_wdata),
		.loc_we(loc_we), .loc_re(loc_re), .loc_rdata(loc_rdata));
	slave_port_monitor #(.BOARD_NUM(4'h0), .HOLD_CYCLES(HOLD))
		u_slave_port_monitor (
		.clk(clk), .reset_n(reset_n), .stb(bus.stb), .io(bus.io),
		.we(bus.we), .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack),
		.stall(bus.stall), .cpu_reset_n(cpu_reset_n),
		.cpu_start(cpu_start), .cpu_start_addr(cpu_start_addr),
		.refresh_en(refresh_en), .bus_request(bus_request),
		.local_bus_grant_ack(grant), .loc_addr(loc_addr),
		.loc_wdata(loc_wdata), .loc_we(loc_we));
	always #4 clk = ~clk;
	// ============================================================
	// local processor stand-in: grants only while running
	always @(posedge clk) begin
		grant <= bus_request & cpu_reset_n & grant_en;
		if (loc_we === 1'b1) begin
			mem[loc_addr] <= loc_wdata;
		end
		// idle read lines toggle so stale data never looks valid
		loc_rdata <= (loc_re === 1'b1) ? mem[loc_addr] : ~loc_rdata;
		if (cpu_start === 1'b1) begin
			starts <= starts + 1;
		end
	end
	// ============================================================
	// register port tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask: check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask: wr
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		s = reg_rdata;
		@(posedge clk);
	endtask: rd
	task automatic idle();
		int n;
		for (n = 0; n < 3000; n++) begin
			rd(HR_STATUS);
			if (s[ST_BUSY] === 1'b0) break;
		end
		if (n == 3000) begin
			error_cnt++;
			results();
		end
	endtask: idle
	task automatic issue(input logic [19:0] a, input logic [7:0] d,
		input logic [7:0] c);
		wr(HR_ADDR_LO, a[7:0]);
		wr(HR_ADDR_MID, a[15:8]);
		wr(HR_ADDR_HI, {4'h0, a[19:16]});
		wr(HR_WDATA, d);
		wr(HR_CMD, c);
	endtask: issue
	task automatic go(input logic [19:0] a, input logic [7:0] d,
		input logic [7:0] c);
		issue(a, d, c);
		idle();
	endtask: go
	// ============================================================
	// scenarios
	task automatic t_power();
		check({7'h0, cpu_reset_n}, 8'h00);
		check({7'h0, refresh_en}, 8'h00);
		rd(HR_STATUS);
		check(s, 8'h00);
	endtask: t_power
	task automatic t_refuse();
		go(WINDOW_BASE, 8'h11, 8'h01);
		rd(HR_STATUS);
		check(s & 8'h04, 8'h04);
		// mode 3 must fall back to a refused single access
		go(WINDOW_BASE, 8'h11, 8'h31);
		rd(HR_STATUS);
		check(s & 8'h04, 8'h04);
	endtask: t_refuse
	task automatic t_park();
		int b;
		b = starts;
		wr(HR_BOARD, 8'h00);
		go(20'h00000, 8'h00, 8'h10);
		rd(HR_STATUS);
		check(s & 8'h1c, 8'h10);
		check(mem[16'h0000], HALT_OPCODE);
		check({7'h0, cpu_reset_n}, 8'h01);
		check(8'(starts - b), 8'h02);
	endtask: t_park
	task automatic t_access();
		logic [19:0] a [4];
		a = '{WINDOW_BASE + 20'h01234, 20'h0fc30, 20'h0fc3f, 20'h0fc47};
		for (int i = 0; i < 4; i++) begin
			go(a[i], 8'h5a ^ 8'(i), {6'h0, i > 0, 1'b1});
			check(mem[a[i][15:0]], 8'h5a ^ 8'(i));
			check({7'h0, loc_io}, {7'h0, i > 0});
			go(a[i], 8'h00, {6'h0, i > 0, 1'b0});
			rd(HR_RDATA);
			check(s, 8'h5a ^ 8'(i));
		end
	endtask: t_access
	task automatic t_stall();
		grant_en <= 1'b0;
		issue(WINDOW_BASE + 20'h00002, 8'h77, 8'h01);
		repeat (20) @(posedge clk);
		rd(HR_STATUS);
		check(s & 8'h03, 8'h03);
		grant_en <= 1'b1;
		idle();
		check(mem[16'h0002], 8'h77);
	endtask: t_stall
	task automatic t_select();
		go(20'h0fc40, 8'h05, 8'h03);
		go(20'h0fc41, STOP_VALUE, 8'h03);
		check({7'h0, cpu_reset_n}, 8'h01);
		go(20'h0fc40, 8'h00, 8'h03);
		go(20'h0fc41, STOP_VALUE, 8'h03);
		check({7'h0, cpu_reset_n}, 8'h00);
		go(20'h0fc41, RUN_VALUE, 8'h03);
		check({7'h0, cpu_reset_n}, 8'h01);
	endtask: t_select
	task automatic t_restart();
		int b;
		go(WINDOW_BASE, 8'hc3, 8'h01);
		b = starts;
		go(20'h00000, 8'h00, 8'h20);
		check(8'(starts - b), 8'h01);
		check(mem[16'h0000], 8'hc3);
		check({7'h0, cpu_reset_n}, 8'h01);
	endtask: t_restart
	task automatic results();
		$display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask: results
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_power();
		t_refuse();
		t_park();
		t_access();
		t_stall();
		t_select();
		t_restart();
		results();
	end
endmodule: slave_processor_host_port_bench
